//--- hdl/lpmc_pkg.sv
// Purpose: shared constants and types of the low power mode controller
// Assumes: 200 MHz system clock
// Notes: times kept in their own unit, cycle counts derived from them
package lpmc_pkg;

   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int CLK_MHZ = 200;
   localparam int FAST_WAKE_US = 6;
   localparam int FAST_WAKE_CYC = FAST_WAKE_US * CLK_MHZ;
   // sync, detect and hand-off cycles spent outside the counter
   localparam int WAKE_OVERHEAD_CYC = 5;
   localparam int WAKE_CNT_W = 11;
   localparam logic [WAKE_CNT_W-1:0] WAKE_LOAD =
      WAKE_CNT_W'(FAST_WAKE_CYC - WAKE_OVERHEAD_CYC);

   // ***************************************************************
   // sizes, synchroniser lanes, reset values
   // ***************************************************************
   localparam int PERIPH_N_DEF = 24;
   localparam int DIV_W_DEF = 3;
   localparam int SYNC_N = 3;
   localparam int SYNC_EXT = 0;
   localparam int SYNC_RTC = 1;
   localparam int SYNC_REF = 2;
   localparam logic RST_ON = 1'h1;
   localparam logic RST_OFF = 1'h0;

   // ***************************************************************
   // power states
   // ***************************************************************
   typedef enum logic [3:0] {
      ST_RUN, ST_WAIT_INT, ST_WAIT_EVT, ST_SERVICE, ST_LP_RUN,
      ST_LP_WAIT, ST_ACT_HALT, ST_HALT, ST_WAKE
   } lpmc_state_e;

   localparam lpmc_state_e RST_STATE = ST_RUN;

endpackage : lpmc_pkg

//--- hdl/lpmc_wake_if.sv
// Purpose: carries synchronised wake inputs and wake timer handshake
// Assumes: all signals in the system clock domain
// Notes: none
`timescale 1ns/1ps
interface lpmc_wake_if;
   logic [lpmc_pkg::SYNC_N-1:0] syncBits;
   logic timerStart;
   logic timerDone;
   modport sync (output syncBits);
   modport timer (input timerStart, output timerDone);
   modport ctrl (input syncBits, input timerDone, output timerStart);
endinterface : lpmc_wake_if

//--- hdl/lpmc_sync.sv
// Purpose: two-flop synchronisers for the asynchronous wake pins
// Assumes: inputs are slow levels from pins or the analog block
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module lpmc_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw pins
   input wire logic [lpmc_pkg::SYNC_N-1:0] rawIn,
   // synchronised side
   lpmc_wake_if.sync wk
);
   import lpmc_pkg::*;

   logic [SYNC_N-1:0] stage1_reg;
   logic [SYNC_N-1:0] stage2_reg;

   genvar i;
   generate
      for (i = 0; i < SYNC_N; i++) begin : g_lane
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               stage1_reg[i] <= RST_OFF;
               stage2_reg[i] <= RST_OFF;
            end else begin
               stage1_reg[i] <= rawIn[i];
               stage2_reg[i] <= stage1_reg[i];
            end
         end
      end
   endgenerate

   assign wk.syncBits = stage2_reg;

endmodule : lpmc_sync

//--- hdl/lpmc_wake_timer.sv
// Purpose: counts the halt wakeup time before the cpu is released
// Assumes: start is a one-cycle pulse
// Notes: done stays high until the next start
`timescale 1ns/1ps
module lpmc_wake_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // handshake
   lpmc_wake_if.timer wk
);
   import lpmc_pkg::*;

   logic [WAKE_CNT_W-1:0] cnt_reg;
   logic busy_reg;
   logic done_reg;
   wire atZero = (cnt_reg == {WAKE_CNT_W{1'h0}});

   // R09 wake time count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= {WAKE_CNT_W{1'h0}};
         busy_reg <= RST_OFF;
         done_reg <= RST_OFF;
      end else if (wk.timerStart) begin
         cnt_reg <= WAKE_LOAD;
         busy_reg <= RST_ON;
         done_reg <= RST_OFF;
      end else if (busy_reg && atZero) begin
         busy_reg <= RST_OFF;
         done_reg <= RST_ON;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - WAKE_CNT_W'(1);
      end
   end

   assign wk.timerDone = done_reg;

endmodule : lpmc_wake_timer

//--- hdl/lpmc_top.sv
// Purpose: steps the device between run, wait, low power and halt states
// Assumes: cpu requests, events and pending bits are on clk
// Notes: all outputs registered; decode from the next state
//
// Contract
// R01 - after any reset the device is in run with cpu clocked
// R02 - wait stops cpu clock, peripherals run; interrupt, event, reset wake
// R03 - low power run: slow oscillator, flash off, ulp regulator, software exit
// R04 - interrupts stay masked in low power modes and never wake them
// R05 - wait event op in low power run enters low power wait
// R06 - low power wait wakes on event back to low power run, or reset
// R07 - active halt keeps only rtc and slow oscillator; rtc, ext irq wake
// R08 - halt stops all clocks, ulp regulator; ext interrupt or reset wake
// R09 - configured fast wake from halt completes within 6 us
// R10 - halt request ignored while any peripheral interrupt is pending
// R11 - wait interrupt op keeps oscillator, main regulator, any irq wakes; only ext or peripheral irq wakes it here, rtc irq is ignored
// R12 - each peripheral clock gated by its enable bit in run and wait
// R13 - wait stops only the cpu; peripherals and irq controller run
// R14 - wait keeps register contents and clock divider unchanged
// R15 - interrupt wakes cpu from wait, cpu services it and resumes
// R16 - main suspend bit sends cpu back to wait after interrupt routine
// R17 - ref off plus fast wake skips reference startup on halt wakeup
// R18 - reset overrides every wake source and returns straight to run
`timescale 1ns/1ps
module lpmc_top #(
   parameter int PeriphN = lpmc_pkg::PERIPH_N_DEF,
   parameter int DivW = lpmc_pkg::DIV_W_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // cpu requests, one-cycle pulses
   input wire logic waitIntReq,
   input wire logic waitEventReq,
   input wire logic haltReq,
   input wire logic lowPowerRunEnter,
   input wire logic lowPowerRunExit,
   input wire logic intServiceDone,
   // configuration levels
   input wire logic mainSuspendBit,
   input wire logic refOffInHalt,
   input wire logic fastWakeBit,
   input wire logic activeHaltSel,
   input wire logic activeHaltUlp,
   input wire logic [PeriphN-1:0] periphClockEnable,
   input wire logic [DivW-1:0] sysClockDivSel,
   // wake sources on clk
   input wire logic [PeriphN-1:0] periphIrqPending,
   input wire logic wakeEvent,
   // asynchronous pins
   input wire logic extIrqRaw,
   input wire logic rtcIrqRaw,
   input wire logic refReadyRaw,
   // clock and power controls
   output logic cpuClockEn,
   output logic [PeriphN-1:0] periphClockEn,
   output logic rtcClockEn,
   output logic mainOscEn,
   output logic lowSpeedOscEn,
   output logic regulatorUlp,
   output logic flashEn,
   output logic refVoltageEn,
   output logic [DivW-1:0] sysClockDiv,
   // cpu notifications and state
   output logic cpuWakeIrq,
   output logic cpuResume,
   output logic haltRefused,
   output lpmc_pkg::lpmc_state_e modeState
);
   import lpmc_pkg::*;

   // ***************************************************************
   // wake inputs and timer
   // ***************************************************************
   lpmc_wake_if wk ();

   lpmc_sync u_sync (
      .clk(clk),
      .rst(rst),
      .rawIn({refReadyRaw, rtcIrqRaw, extIrqRaw}),
      .wk(wk.sync)
   );

   lpmc_wake_timer u_timer (
      .clk(clk),
      .rst(rst),
      .wk(wk.timer)
   );

   // ***************************************************************
   // decode
   // ***************************************************************
   lpmc_state_e state_reg;
   lpmc_state_e state_next;
   logic fromEvt_reg;
   logic fromEvt_next;

   wire extIrq = wk.syncBits[SYNC_EXT];
   wire rtcIrq = wk.syncBits[SYNC_RTC];
   wire refReady = wk.syncBits[SYNC_REF];
   wire periphIrq = |periphIrqPending;
   wire irqAny = extIrq | periphIrq;
   wire haltTake = haltReq & ~periphIrq;
   wire haltNoTake = haltReq & periphIrq;
   wire waitRef = refOffInHalt & ~fastWakeBit;
   wire wakeReady = wk.timerDone & (~waitRef | refReady);
   wire inRunLike = (state_reg == ST_RUN) | (state_reg == ST_LP_RUN);
   wire enterWake = (state_next == ST_WAKE) & (state_reg != ST_WAKE);
   wire enterServ = (state_next == ST_SERVICE) & (state_reg != ST_SERVICE);
   wire resumeNext = ((state_reg == ST_WAIT_EVT) | (state_reg == ST_LP_WAIT))
                     & wakeEvent;
   wire runNoWait = (state_reg == ST_RUN) & ~waitIntReq & ~waitEventReq;
   wire refusedNext = runNoWait & haltNoTake;

   assign wk.timerStart = enterWake;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      state_next = state_reg;
      fromEvt_next = fromEvt_reg;
      unique case (state_reg)
         ST_RUN: begin
            // R11 wait for interrupt
            if (waitIntReq) state_next = ST_WAIT_INT;
            // R02 wait for event
            else if (waitEventReq) state_next = ST_WAIT_EVT;
            // R10 halt held off
            else if (haltTake) state_next = activeHaltSel ? ST_ACT_HALT : ST_HALT;
            // R03 software entry
            else if (lowPowerRunEnter) state_next = ST_LP_RUN;
         end
         ST_WAIT_INT: begin
            // R15 interrupt wakes cpu
            if (irqAny) state_next = ST_SERVICE;
            if (irqAny) fromEvt_next = 1'h0;
         end
         ST_WAIT_EVT: begin
            // R02 event resumes
            if (wakeEvent) state_next = ST_RUN;
            else if (irqAny) state_next = ST_SERVICE;
            if (!wakeEvent && irqAny) fromEvt_next = 1'h1;
         end
         ST_SERVICE: begin
            // R16 suspend main context
            if (intServiceDone && fromEvt_reg) state_next = ST_WAIT_EVT;
            else if (intServiceDone && mainSuspendBit) state_next = ST_WAIT_INT;
            else if (intServiceDone) state_next = ST_RUN;
         end
         ST_LP_RUN: begin
            // R03 software exit
            if (lowPowerRunExit) state_next = ST_RUN;
            // R05 enter low power wait
            else if (waitEventReq) state_next = ST_LP_WAIT;
         end
         ST_LP_WAIT: begin
            // R04 interrupts ignored here
            // R06 event back to lp run
            if (wakeEvent) state_next = ST_LP_RUN;
         end
         ST_ACT_HALT: begin
            // R07 rtc or ext wake
            if (extIrq || rtcIrq) state_next = ST_WAKE;
         end
         ST_HALT: begin
            // R08 only ext wake
            if (extIrq) state_next = ST_WAKE;
         end
         ST_WAKE: begin
            // R17 reference wait skipped on fast wake
            if (wakeReady) state_next = ST_SERVICE;
            if (wakeReady) fromEvt_next = 1'h0;
         end
      endcase
   end

   // ***************************************************************
   // output decode from next state
   // ***************************************************************
   wire haltNext = (state_next == ST_HALT) | (state_next == ST_ACT_HALT);
   wire lpNext = (state_next == ST_LP_RUN) | (state_next == ST_LP_WAIT);
   // R13 only cpu stops in wait
   wire cpuNext = (state_next == ST_RUN) | (state_next == ST_SERVICE)
                  | (state_next == ST_LP_RUN);
   // R12 per-peripheral gating
   wire [PeriphN-1:0] periphNext = haltNext ? {PeriphN{1'h0}} : periphClockEnable;
   wire mainOscNext = ~haltNext & ~lpNext;
   wire lowOscNext = lpNext | (state_next == ST_ACT_HALT);
   wire rtcNext = (state_next != ST_HALT);
   // R08 ulp in halt, lp modes
   wire ulpNext = lpNext | (state_next == ST_HALT)
                  | ((state_next == ST_ACT_HALT) & activeHaltUlp);
   wire flashNext = ~lpNext & ~haltNext;
   wire refNext = ~(haltNext & refOffInHalt);

   // ***************************************************************
   // state and output registers
   // ***************************************************************
   logic cpuClockEn_reg;
   logic [PeriphN-1:0] periphClockEn_reg;
   logic rtcClockEn_reg;
   logic mainOscEn_reg;
   logic lowSpeedOscEn_reg;
   logic regulatorUlp_reg;
   logic flashEn_reg;
   logic refVoltageEn_reg;
   logic [DivW-1:0] sysClockDiv_reg;
   logic cpuWakeIrq_reg;
   logic cpuResume_reg;
   logic haltRefused_reg;

   // R01 reset lands in run
   // R18 reset beats every wake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= RST_STATE;
         fromEvt_reg <= RST_OFF;
      end else begin
         state_reg <= state_next;
         fromEvt_reg <= fromEvt_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cpuClockEn_reg <= RST_ON;
         periphClockEn_reg <= {PeriphN{RST_OFF}};
         rtcClockEn_reg <= RST_ON;
         mainOscEn_reg <= RST_ON;
         lowSpeedOscEn_reg <= RST_OFF;
         regulatorUlp_reg <= RST_OFF;
         flashEn_reg <= RST_ON;
         refVoltageEn_reg <= RST_ON;
      end else begin
         cpuClockEn_reg <= cpuNext;
         periphClockEn_reg <= periphNext;
         rtcClockEn_reg <= rtcNext;
         mainOscEn_reg <= mainOscNext;
         lowSpeedOscEn_reg <= lowOscNext;
         regulatorUlp_reg <= ulpNext;
         flashEn_reg <= flashNext;
         refVoltageEn_reg <= refNext;
      end
   end

   // R14 divider frozen outside run and lp run
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sysClockDiv_reg <= {DivW{RST_OFF}};
      end else if (inRunLike) begin
         sysClockDiv_reg <= sysClockDivSel;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cpuWakeIrq_reg <= RST_OFF;
         cpuResume_reg <= RST_OFF;
         haltRefused_reg <= RST_OFF;
      end else begin
         cpuWakeIrq_reg <= enterServ;
         cpuResume_reg <= resumeNext;
         haltRefused_reg <= refusedNext;
      end
   end

   assign cpuClockEn = cpuClockEn_reg;
   assign periphClockEn = periphClockEn_reg;
   assign rtcClockEn = rtcClockEn_reg;
   assign mainOscEn = mainOscEn_reg;
   assign lowSpeedOscEn = lowSpeedOscEn_reg;
   assign regulatorUlp = regulatorUlp_reg;
   assign flashEn = flashEn_reg;
   assign refVoltageEn = refVoltageEn_reg;
   assign sysClockDiv = sysClockDiv_reg;
   assign cpuWakeIrq = cpuWakeIrq_reg;
   assign cpuResume = cpuResume_reg;
   assign haltRefused = haltRefused_reg;
   assign modeState = state_reg;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // two sync flops and the detect edge come before the wake state
   localparam logic [WAKE_CNT_W-1:0] WakeBound = WAKE_CNT_W'(FAST_WAKE_CYC - 3);
   wire inWait = (state_reg == ST_WAIT_INT) | (state_reg == ST_WAIT_EVT);
   logic [WAKE_CNT_W-1:0] wakeCnt_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) wakeCnt_reg <= {WAKE_CNT_W{1'h0}};
      else if (state_reg != ST_WAKE) wakeCnt_reg <= {WAKE_CNT_W{1'h0}};
      else if (wakeCnt_reg != {WAKE_CNT_W{1'h1}}) wakeCnt_reg <= wakeCnt_reg + WAKE_CNT_W'(1);
   end

   sequence lpWaitEvent;
      (state_reg == ST_LP_WAIT) && wakeEvent;
   endsequence

   reset_run_a: assert property ($fell(rst) |-> state_reg == ST_RUN && cpuClockEn) // R01
      else $error("not in run after reset");
   wait_cpu_off_a: assert property (inWait && $past(inWait) |->                   // R02
      !cpuClockEn && periphClockEn == $past(periphClockEnable) && !regulatorUlp)
      else $error("wait clocks wrong");
   lp_run_a: assert property (state_reg == ST_LP_RUN |->                          // R03
      cpuClockEn && lowSpeedOscEn && !mainOscEn && !flashEn && regulatorUlp)
      else $error("low power run settings wrong");
   lp_no_irq_a: assert property ((state_reg == ST_LP_WAIT) && !wakeEvent          // R04
      |=> state_reg == ST_LP_WAIT)
      else $error("low power wait left without event");
   lp_wait_enter_a: assert property ((state_reg == ST_LP_RUN) && waitEventReq     // R05
      && !lowPowerRunExit |=> state_reg == ST_LP_WAIT && !cpuClockEn)
      else $error("low power wait not entered");
   lp_wait_exit_a: assert property (lpWaitEvent |=>                               // R06
      state_reg == ST_LP_RUN && cpuResume)
      else $error("event did not return to lp run");
   act_halt_rtc_a: assert property (state_reg == ST_ACT_HALT |->                  // R07
      rtcClockEn && lowSpeedOscEn && !cpuClockEn && periphClockEn == '0)
      else $error("active halt clocks wrong");
   halt_clocks_a: assert property (state_reg == ST_HALT |->                       // R08
      !mainOscEn && !lowSpeedOscEn && !cpuClockEn && !rtcClockEn && regulatorUlp)
      else $error("halt clocks wrong");
   fast_wake_a: assert property ((state_reg == ST_WAKE) && refOffInHalt && fastWakeBit // R09
      |-> wakeCnt_reg < WakeBound) else $error("fast wake too slow");
   halt_refused_a: assert property (refusedNext |=>                               // R10
      state_reg == ST_RUN && haltRefused)
      else $error("halt taken with irq pending");
   serve_wake_a: assert property ((state_reg == ST_WAIT_INT) && irqAny |=>        // R15
      state_reg == ST_SERVICE && cpuWakeIrq && cpuClockEn)
      else $error("interrupt did not wake cpu");
   suspend_back_a: assert property ((state_reg == ST_SERVICE) && intServiceDone   // R16
      && mainSuspendBit && !fromEvt_reg |=> state_reg == ST_WAIT_INT)
      else $error("suspend bit ignored");
   div_hold_a: assert property (inWait && $past(inWait) |-> $stable(sysClockDiv)) // R14
      else $error("divider changed in wait");

endmodule : lpmc_top

//--- bench/lpmc_cpu_model.sv
// Purpose: cpu core model issuing low power requests and serving wakes
// Assumes: requests change on the falling edge and last one cycle
// Notes: svcDelay stretches the interrupt routine for slow service
`timescale 1ns/1ps
module lpmc_cpu_model (
   // clock
   input wire logic clk,
   // from controller and bench
   input wire logic cpuWakeIrq,
   input wire logic [7:0] svcDelay,
   // requests
   output logic waitIntReq,
   output logic waitEventReq,
   output logic haltReq,
   output logic lowPowerRunEnter,
   output logic lowPowerRunExit,
   output logic intServiceDone
);
   logic [4:0] opReg = 5'h00;

   assign {waitIntReq, waitEventReq, haltReq, lowPowerRunEnter, lowPowerRunExit} = opReg;

   // one instruction per call, held one full cycle
   task automatic issue(input logic [4:0] op);
      @(negedge clk);
      opReg = op;
      @(negedge clk);
      opReg = 5'h00;
   endtask : issue

   // serve only a signalled wake
   // masked sources are never served, so low power modes see no routine end
   always begin
      intServiceDone = 1'h0;
      @(posedge clk iff cpuWakeIrq === 1'h1);
      repeat (svcDelay) @(negedge clk);
      @(negedge clk);
      intServiceDone = 1'h1;
      @(negedge clk);
   end
endmodule : lpmc_cpu_model

//--- bench/low_power_mode_controller_test.sv
// Purpose: walks the controller through every power state and every wake path except irq in event wait and ext irq in active halt
// Assumes: bench drives inputs at the falling edge
// Notes: halt wake timing uses the full 6 us count, about 1200 cycles
`timescale 1ns/1ps
module low_power_mode_controller_test;
   import lpmc_pkg::*;
   localparam logic [4:0] OP_WI = 5'h10;
   localparam logic [4:0] OP_WE = 5'h08;
   localparam logic [4:0] OP_HALT = 5'h04;
   localparam logic [4:0] OP_LPE = 5'h02;
   localparam logic [4:0] OP_LPX = 5'h01;
   logic clk, rst, waitIntReq, waitEventReq, haltReq, lowPowerRunEnter, lowPowerRunExit;
   logic intServiceDone, mainSuspendBit, refOffInHalt, fastWakeBit, activeHaltSel;
   logic activeHaltUlp, wakeEvent, extIrqRaw, rtcIrqRaw, refReadyRaw;
   logic [23:0] periphClockEnable, periphIrqPending, periphClockEn;
   logic [2:0] sysClockDivSel, sysClockDiv;
   logic cpuClockEn, rtcClockEn, mainOscEn, lowSpeedOscEn, regulatorUlp, flashEn;
   logic refVoltageEn, cpuWakeIrq, cpuResume, haltRefused, seenRes, seenRef;
   logic [7:0] svcDelay;
   lpmc_state_e modeState;
   int errorCnt = 0;
   int cmpCount = 0;
   int n;

   lpmc_top DUT (.clk(clk), .rst(rst), .waitIntReq(waitIntReq), .waitEventReq(waitEventReq),
      .haltReq(haltReq), .lowPowerRunEnter(lowPowerRunEnter),
      .lowPowerRunExit(lowPowerRunExit), .intServiceDone(intServiceDone),
      .mainSuspendBit(mainSuspendBit), .refOffInHalt(refOffInHalt),
      .fastWakeBit(fastWakeBit), .activeHaltSel(activeHaltSel),
      .activeHaltUlp(activeHaltUlp), .periphClockEnable(periphClockEnable),
      .sysClockDivSel(sysClockDivSel), .periphIrqPending(periphIrqPending),
      .wakeEvent(wakeEvent), .extIrqRaw(extIrqRaw), .rtcIrqRaw(rtcIrqRaw),
      .refReadyRaw(refReadyRaw), .cpuClockEn(cpuClockEn), .periphClockEn(periphClockEn),
      .rtcClockEn(rtcClockEn), .mainOscEn(mainOscEn), .lowSpeedOscEn(lowSpeedOscEn),
      .regulatorUlp(regulatorUlp), .flashEn(flashEn), .refVoltageEn(refVoltageEn),
      .sysClockDiv(sysClockDiv), .cpuWakeIrq(cpuWakeIrq), .cpuResume(cpuResume),
      .haltRefused(haltRefused), .modeState(modeState));

   lpmc_cpu_model cpu (.clk(clk), .cpuWakeIrq(cpuWakeIrq), .svcDelay(svcDelay),
      .waitIntReq(waitIntReq), .waitEventReq(waitEventReq), .haltReq(haltReq),
      .lowPowerRunEnter(lowPowerRunEnter), .lowPowerRunExit(lowPowerRunExit),
      .intServiceDone(intServiceDone));

   // ***************************************************************
   // compare tasks
   // ***************************************************************
   task automatic fail(input string what);
      errorCnt++;
      $display("CHECK FAILED at %0t: %s", $time, what);
   endtask : fail

   task automatic chk1(input logic got, input logic exp, input string what);
      cmpCount++;
      if (got !== exp) fail(what);
   endtask : chk1

   task automatic chkv(input logic [23:0] got, input logic [23:0] exp, input string what);
      cmpCount++;
      if (got !== exp) fail(what);
   endtask : chkv

   task automatic chks(input lpmc_state_e got, input lpmc_state_e exp, input string what);
      cmpCount++;
      if (got !== exp) fail(what);
   endtask : chks

   // expected bits: cpu, main osc, slow osc, ulp, flash, rtc
   task automatic chk_pwr(input lpmc_state_e s, input logic [5:0] e);
      chks(modeState, s, "mode state");
      chk1(cpuClockEn, e[5], "cpu clock");
      chk1(mainOscEn, e[4], "main osc");
      chk1(lowSpeedOscEn, e[3], "slow osc");
      chk1(regulatorUlp, e[2], "regulator mode");
      chk1(flashEn, e[1], "flash enable");
      chk1(rtcClockEn, e[0], "rtc clock");
   endtask : chk_pwr

   task automatic wait_state(input lpmc_state_e s, input int lim, output int cnt);
      cnt = 0;
      while (modeState !== s && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
      chks(modeState, s, "state not reached");
   endtask : wait_state

   // pulses may land in this cycle or the next
   task automatic watch2();
      seenRes = cpuResume;
      seenRef = haltRefused;
      @(negedge clk);
      seenRes = seenRes | cpuResume;
      seenRef = seenRef | haltRefused;
   endtask : watch2

   task automatic closeOut();
      $display("comparisons %0d, mismatches %0d", cmpCount, errorCnt);
      if (errorCnt == 0 && cmpCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : closeOut

   // ***************************************************************
   // clock, watchdog, tests
   // ***************************************************************
   initial clk = 1'h0;
   always #2.5 clk = ~clk;

   initial begin
      #100us;
      fail("watchdog");
      closeOut();
   end

   initial begin
      rst = 1'h1;
      {mainSuspendBit, refOffInHalt, fastWakeBit, activeHaltSel, activeHaltUlp} = 5'h00;
      {wakeEvent, extIrqRaw, rtcIrqRaw, refReadyRaw} = 4'h0;
      periphClockEnable = 24'hA5C3F0;
      periphIrqPending = 24'h000000;
      sysClockDivSel = 3'h2;
      svcDelay = 8'h00;
      repeat (10) @(negedge clk);
      chk_pwr(ST_RUN, 6'h33);
      rst = 1'h0;
      repeat (2) @(negedge clk);
      chkv(periphClockEn, 24'hA5C3F0, "periph gating");
      cpu.issue(OP_WI);
      chk_pwr(ST_WAIT_INT, 6'h13);
      periphClockEnable = 24'h5A3C0F;
      sysClockDivSel = 3'h5;
      @(negedge clk);
      chkv(periphClockEn, 24'h5A3C0F, "gating in wait");
      chkv({21'h0, sysClockDiv}, 24'h2, "divider held");
      mainSuspendBit = 1'h1;
      periphIrqPending = 24'h000100;
      wait_state(ST_SERVICE, 10, n);
      chk1(cpuWakeIrq, 1'h1, "wake irq");
      periphIrqPending = 24'h000000;
      wait_state(ST_WAIT_INT, 10, n);
      mainSuspendBit = 1'h0;
      svcDelay = 8'h14;
      extIrqRaw = 1'h1;
      wait_state(ST_SERVICE, 10, n);
      extIrqRaw = 1'h0;
      wait_state(ST_RUN, 40, n);
      cpu.issue(OP_WE);
      chk_pwr(ST_WAIT_EVT, 6'h13);
      wakeEvent = 1'h1;
      @(negedge clk);
      wakeEvent = 1'h0;
      watch2();
      chks(modeState, ST_RUN, "event wake");
      chk1(seenRes, 1'h1, "resume pulse");
      cpu.issue(OP_LPE);
      chk_pwr(ST_LP_RUN, 6'h2D);
      periphIrqPending = 24'h000001;
      extIrqRaw = 1'h1;
      repeat (5) @(negedge clk);
      chks(modeState, ST_LP_RUN, "irq left lp run");
      cpu.issue(OP_WE);
      chk_pwr(ST_LP_WAIT, 6'h0D);
      repeat (5) @(negedge clk);
      chks(modeState, ST_LP_WAIT, "irq left lp wait");
      periphIrqPending = 24'h000000;
      extIrqRaw = 1'h0;
      wakeEvent = 1'h1;
      @(negedge clk);
      wakeEvent = 1'h0;
      watch2();
      chks(modeState, ST_LP_RUN, "lp wait event");
      chk1(seenRes, 1'h1, "lp resume");
      cpu.issue(OP_LPX);
      chks(modeState, ST_RUN, "lp exit");
      periphIrqPending = 24'h800000;
      cpu.issue(OP_HALT);
      watch2();
      chks(modeState, ST_RUN, "halt taken");
      chk1(seenRef, 1'h1, "halt refusal");
      periphIrqPending = 24'h000000;
      {refOffInHalt, fastWakeBit} = 2'h3;
      cpu.issue(OP_HALT);
      chk_pwr(ST_HALT, 6'h04);
      chkv(periphClockEn, 24'h0, "halt periph");
      chk1(refVoltageEn, 1'h0, "reference off");
      rtcIrqRaw = 1'h1;
      repeat (6) @(negedge clk);
      chks(modeState, ST_HALT, "rtc woke halt");
      rtcIrqRaw = 1'h0;
      extIrqRaw = 1'h1;
      wait_state(ST_SERVICE, 1300, n);
      chk1(n <= FAST_WAKE_CYC, 1'h1, "fast wake late");
      extIrqRaw = 1'h0;
      wait_state(ST_RUN, 40, n);
      fastWakeBit = 1'h0;
      cpu.issue(OP_HALT);
      extIrqRaw = 1'h1;
      repeat (1400) @(negedge clk);
      chks(modeState, ST_WAKE, "reference wait skipped");
      refReadyRaw = 1'h1;
      wait_state(ST_SERVICE, 20, n);
      extIrqRaw = 1'h0;
      wait_state(ST_RUN, 40, n);
      {fastWakeBit, activeHaltSel, activeHaltUlp} = 3'h7;
      cpu.issue(OP_HALT);
      chk_pwr(ST_ACT_HALT, 6'h0D);
      chkv(periphClockEn, 24'h0, "active halt periph");
      rtcIrqRaw = 1'h1;
      wait_state(ST_SERVICE, 1300, n);
      rtcIrqRaw = 1'h0;
      wait_state(ST_RUN, 40, n);
      activeHaltSel = 1'h0;
      cpu.issue(OP_HALT);
      chks(modeState, ST_HALT, "halt again");
      extIrqRaw = 1'h1;
      rst = 1'h1;
      @(negedge clk);
      chk_pwr(ST_RUN, 6'h33);
      rst = 1'h0;
      extIrqRaw = 1'h0;
      repeat (3) @(negedge clk);
      chk_pwr(ST_RUN, 6'h33);
      closeOut();
   end
endmodule : low_power_mode_controller_test
